// ===== inc/imu_link_if.sv
/*
  SPI-style link between host and sensor: two chip selects, clock, data in,
  data out. Assumes the host makes the link clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface imu_link_if;
  logic sck;
  logic accel_cs_n;
  logic gyro_cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic interface_select_pin;
  modport host_end (output sck, output accel_cs_n, output gyro_cs_n, output mosi,
                    input miso, input miso_oe);
  modport sensor_end (input sck, input accel_cs_n, input gyro_cs_n, input mosi,
                      output miso, output miso_oe, input interface_select_pin);
endinterface : imu_link_if
`default_nettype wire

// ===== inc/imu_pkg.sv
/*
  Shared constants for the inertial sensor control block and its host end:
  register indices, power codes, timing counts.
  Assumes a 10 MHz system clock on both ends.
*/
package imu_pkg;
  // Clock
  localparam int unsigned CLK_HZ = 10000000;
  // Sensor register indices (7-bit address space)
  localparam logic [6:0] REG_ACCEL_ID     = 7'h00;
  localparam logic [6:0] REG_ACCEL_DATA0  = 7'h12;
  localparam logic [6:0] REG_ACCEL_TIME0  = 7'h18;
  localparam logic [6:0] REG_ACCEL_TEMP0  = 7'h22;
  localparam logic [6:0] REG_ACCEL_PWR    = 7'h7D;
  localparam logic [6:0] REG_GYRO_DATA0   = 7'h02;
  localparam logic [6:0] REG_GYRO_LPM     = 7'h11;
  localparam logic [6:0] REG_GYRO_SOFTRST = 7'h14;
  localparam logic [7:0] SOFT_RESET_CMD   = 8'hB6;
  // Identity value, arbitrary
  localparam logic [7:0] ACCEL_ID_VALUE   = 8'h5A;
  // Power codes
  localparam logic [7:0] ACCEL_PWR_ON     = 8'h04;
  localparam logic [7:0] ACCEL_PWR_OFF    = 8'h00;
  localparam logic [7:0] GYRO_LPM_NORMAL  = 8'h00;
  localparam logic [7:0] GYRO_LPM_SUSPEND = 8'h80;
  localparam logic [7:0] GYRO_LPM_DEEP    = 8'h20;
  // Sensor time tick: 39.0625 us
  localparam int unsigned TICK_NS         = 39063;
  localparam logic [8:0] TICK_CYCLES      = 9'(((TICK_NS * (CLK_HZ / 1000000)) / 1000) - 1);
  localparam int unsigned SENSOR_TIME_W   = 24;
  // Host waits in microseconds
  localparam int unsigned ACCEL_BOOT_US   = 1000;
  localparam int unsigned ACCEL_MODE_US   = 5000;
  localparam int unsigned ACCEL_DATA_US   = 50000;
  localparam int unsigned GYRO_SETTLE_US  = 30000;
  localparam int unsigned WRITE_GAP_US    = 2;
  localparam int unsigned ACCEL_BOOT_CYC  = ACCEL_BOOT_US * (CLK_HZ / 1000000);
  localparam int unsigned ACCEL_MODE_CYC  = ACCEL_MODE_US * (CLK_HZ / 1000000);
  localparam int unsigned ACCEL_DATA_CYC  = ACCEL_DATA_US * (CLK_HZ / 1000000);
  localparam int unsigned GYRO_SETTLE_CYC = GYRO_SETTLE_US * (CLK_HZ / 1000000);
  localparam logic [7:0]  WRITE_GAP_CYC   = 8'(WRITE_GAP_US * (CLK_HZ / 1000000));
  // Link half period minus one, in system clocks (link clock made by host)
  localparam logic [3:0]  SCK_HALF_CYC    = 4'h4;
  // Host register map (AHB-Lite byte addresses)
  localparam logic [7:0] HOST_CTRL        = 8'h00;
  localparam logic [7:0] HOST_ADDR        = 8'h04;
  localparam logic [7:0] HOST_WDATA       = 8'h08;
  localparam logic [7:0] HOST_RDATA       = 8'h0C;
  localparam logic [7:0] HOST_STATUS      = 8'h10;
  // HOST_CTRL fields
  localparam int unsigned CTRL_GO_BIT     = 0;
  localparam int unsigned CTRL_READ_BIT   = 1;
  localparam int unsigned CTRL_GYRO_BIT   = 2;
  localparam int unsigned CTRL_LEN_LSB    = 8;
  // Link op state
  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_CMD   = 3'b001,
    L_DATA  = 3'b010,
    L_DONE  = 3'b011,
    L_GAP   = 3'b100
  } link_state_t;
endpackage : imu_pkg

// ===== src/imu_host.sv
/*
  Host end: AHB-Lite slave with command registers, drives SPI frames to the
  sensor, enforces boot, settle and write-gap waits.
  Assumes one AHB-Lite master, single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module imu_host
  import imu_pkg::*;
(
  // System
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // AHB-Lite
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Link
  imu_link_if.host_end     link
);
  link_state_t state;
  logic [31:0] ctrl;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [31:0] rdata;
  logic [7:0]  wr_addr;
  logic        wr_pend;
  logic [3:0]  half_cnt;
  logic [2:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  byte_left;
  logic [1:0]  rbyte;
  logic [19:0] hold_cnt;
  logic        gyro_susp;
  logic [2:0]  miso_s;
  logic        busy;

  wire go        = wr_pend && (wr_addr == HOST_CTRL) && i_hwdata[CTRL_GO_BIT];
  wire hold_done = (hold_cnt == 20'h0);
  wire half_tick = (half_cnt == SCK_HALF_CYC);
  wire is_gyro   = ctrl[CTRL_GYRO_BIT];
  wire is_rd     = ctrl[CTRL_READ_BIT];
  wire [7:0] cmd_byte = {is_rd, addr};
  wire miso_in   = (miso_s[1] == miso_s[2]) ? miso_s[2] : 1'b0;
  wire sel_rd    = (wr_addr == HOST_RDATA);
  wire [31:0] status_word = {28'h0, gyro_susp, !hold_done, busy, state == L_IDLE};
  wire [19:0] gap_cyc = (is_gyro && gyro_susp) ? 20'(WRITE_GAP_CYC) : 20'h1;
  wire power_w   = !is_rd && (is_gyro ? addr == REG_GYRO_LPM : addr == REG_ACCEL_PWR);

  // AHB data phase capture; answer is zero wait
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      o_hrdata <= 32'h0;
    end else begin
      wr_pend <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
      if (i_hsel && i_htrans[1] && i_hready) wr_addr <= i_haddr;
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
        case (i_haddr)
          HOST_CTRL:   o_hrdata <= ctrl;
          HOST_ADDR:   o_hrdata <= {25'h0, addr};
          HOST_WDATA:  o_hrdata <= {24'h0, wdata};
          HOST_RDATA:  o_hrdata <= rdata;
          HOST_STATUS: o_hrdata <= status_word;
          default:     o_hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Link engine; waits follow each write of power control
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state     <= L_IDLE;
      ctrl      <= 32'h0;
      addr      <= 7'h00;
      wdata     <= 8'h00;
      rdata     <= 32'h0;
      half_cnt  <= 4'h0;
      bit_cnt   <= 3'h0;
      shift     <= 8'h00;
      byte_left <= 8'h00;
      rbyte     <= 2'h0;
      hold_cnt  <= 20'(GYRO_SETTLE_CYC);
      gyro_susp <= 1'b0;
      busy      <= 1'b0;
      miso_s    <= 3'h0;
      link.sck        <= 1'b0;
      link.accel_cs_n <= 1'b1;
      link.gyro_cs_n  <= 1'b1;
      link.mosi       <= 1'b0;
    end else begin
      miso_s <= {miso_s[1:0], link.miso};
      if (!hold_done) hold_cnt <= hold_cnt - 20'h1;
      if (wr_pend && state == L_IDLE && wr_addr == HOST_ADDR) addr <= i_hwdata[6:0];
      if (wr_pend && state == L_IDLE && wr_addr == HOST_WDATA) wdata <= i_hwdata[7:0];
      case (state)
        L_IDLE: begin
          busy <= 1'b0;
          if (go && hold_done) begin
            ctrl      <= i_hwdata;
            byte_left <= i_hwdata[CTRL_LEN_LSB +: 8];
            busy      <= 1'b1;
            state     <= L_CMD;
            rdata     <= 32'h0;
            rbyte     <= 2'h0;
          end
        end
        L_CMD: begin
          if (is_gyro) link.gyro_cs_n <= 1'b0;
          else link.accel_cs_n <= 1'b0;
          shift    <= cmd_byte;
          link.mosi <= cmd_byte[7];
          bit_cnt  <= 3'h0;
          half_cnt <= 4'h0;
          state    <= L_DATA;
        end
        L_DATA: begin
          half_cnt <= half_tick ? 4'h0 : half_cnt + 4'h1;
          if (half_tick) begin
            link.sck <= !link.sck;
            // Sample on the fall: sync plus slave delay exceed half a period
            if (link.sck) begin
              shift <= {shift[6:0], miso_in};
              bit_cnt <= bit_cnt + 3'h1;
              link.mosi <= shift[6];
              if (bit_cnt == 3'h7) begin
                if (byte_left != ctrl[CTRL_LEN_LSB +: 8] && is_rd) begin
                  rdata[{rbyte, 3'b000} +: 8] <= {shift[6:0], miso_in};
                  rbyte <= rbyte + 2'h1;
                end
                if (byte_left == 8'h00) state <= L_DONE;
                else begin
                  byte_left <= byte_left - 8'h01;
                  shift     <= is_rd ? 8'h00 : wdata;
                  link.mosi <= is_rd ? 1'b0 : wdata[7];
                end
              end
            end
          end
        end
        L_DONE: begin
          link.accel_cs_n <= 1'b1;
          link.gyro_cs_n  <= 1'b1;
          link.sck        <= 1'b0;
          if (power_w && is_gyro) begin
            gyro_susp <= (wdata == GYRO_LPM_SUSPEND);
            hold_cnt  <= 20'(GYRO_SETTLE_CYC);
          end else if (power_w) begin
            hold_cnt <= (wdata == ACCEL_PWR_ON) ? 20'(ACCEL_DATA_CYC) : 20'(ACCEL_MODE_CYC);
          end else begin
            hold_cnt <= gap_cyc;
          end
          state <= L_GAP;
        end
        L_GAP: state <= L_IDLE;
        default: state <= L_IDLE;
      endcase
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
endmodule : imu_host
`default_nettype wire

// ===== src/imu_sensor.sv
/*
  Sensor end: interface selection, accel and gyro power modes, data shadowing,
  burst address increment, sensor-time counter, SPI slave on link pins.
  Assumes link pins are asynchronous; the host makes the link clock.
*/
// Chosen here: the AHB-Lite register port and the register offsets.
// Contract
// - Gyro interface taken from select pin
// - Accel starts I2C, SPI after CS rise
// - Host does dummy SPI read first
// - Reset: gyro normal, accel suspended
// - Accel 0x04 normal, 0x00 suspend
// - Accel power gates temperature too
// - Host waits 1ms boot, 5ms mode
// - Host waits 1ms, writes 4, waits 50ms
// - Gyro suspend holds data and config
// - Gyro 0x80 suspend, 0x00/softreset exits
// - Gyro 0x20 deep suspend loses config
// - Host rewrites settings after deep suspend
// - Host waits 30ms after gyro changes
// - Host gaps writes in gyro suspend
// - Data 16-bit, temperature 11-bit signed
// - Low byte read freezes high byte
// - Host reads low before high byte
// - Burst read auto-increments address
// - Burst read locks all sensor outputs; sensor time still counts
// - 24-bit time counter per 39.0625us
// - Power-on reset clears all selections
`timescale 1ns/1ps
`default_nettype none
module imu_sensor
  import imu_pkg::*;
(
  // System
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // Link
  imu_link_if.sensor_end   link,
  // Sample sources
  input  wire logic [47:0] i_accel_sample,
  input  wire logic [47:0] i_gyro_sample,
  input  wire logic [10:0] i_temp_sample,
  input  wire logic        i_sample_strobe,
  // Status
  output logic             o_accel_spi_mode,
  output logic             o_gyro_spi_mode,
  output logic             o_accel_active,
  output logic [1:0]       o_gyro_mode,
  output logic [23:0]      o_sensor_time
);
  // Three-stage synchronisers on link pins
  logic [2:0] sck_s;
  logic [2:0] acs_s;
  logic [2:0] gcs_s;
  logic [2:0] mosi_s;
  logic sck_q, acs_q, gcs_q, mosi_q;
  logic accel_spi;
  logic gyro_spi;
  logic [7:0] accel_pwr;
  logic [7:0] gyro_lpm;
  logic [47:0] accel_data;
  logic [47:0] gyro_data;
  logic [10:0] temp_data;
  logic [23:0] stime;
  logic [8:0]  tick_cnt;
  logic [15:0] shift_in;
  logic [7:0]  shift_out;
  logic [3:0]  bit_cnt;
  logic        is_read;
  logic        first_byte;
  logic [6:0]  addr;
  logic        burst_active;
  logic [7:0]  shadow_hi;
  logic [7:0]  miso_bit_src;
  logic        was_gyro;
  logic [7:0]  read_byte;
  logic [7:0]  gyro_cfg;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_s  <= 3'h0;
      acs_s  <= 3'h7;
      gcs_s  <= 3'h7;
      mosi_s <= 3'h0;
    end else begin
      sck_s  <= {sck_s[1:0], link.sck};
      acs_s  <= {acs_s[1:0], link.accel_cs_n};
      gcs_s  <= {gcs_s[1:0], link.gyro_cs_n};
      mosi_s <= {mosi_s[1:0], link.mosi};
    end
  end

  // Level counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_q  <= 1'b0;
      acs_q  <= 1'b1;
      gcs_q  <= 1'b1;
      mosi_q <= 1'b0;
    end else begin
      if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
      if (acs_s[1] == acs_s[2]) acs_q <= acs_s[2];
      if (gcs_s[1] == gcs_s[2]) gcs_q <= gcs_s[2];
      if (mosi_s[1] == mosi_s[2]) mosi_q <= mosi_s[2];
    end
  end

  wire sck_rise   = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_q;
  wire sck_fall   = (sck_s[1] == sck_s[2]) && !sck_s[2] && sck_q;
  wire acs_rise   = (acs_s[1] == acs_s[2]) && acs_s[2] && !acs_q;
  wire gcs_rise   = (gcs_s[1] == gcs_s[2]) && gcs_s[2] && !gcs_q;
  wire frame_end  = acs_rise || gcs_rise;
  wire any_sel    = !acs_q || !gcs_q;
  wire sel_gyro   = !gcs_q;
  wire byte_done  = sck_rise && (bit_cnt == 4'h7);
  wire [7:0] wr_byte = {shift_in[6:0], mosi_q};
  wire accel_on   = (accel_pwr == ACCEL_PWR_ON);
  wire gyro_susp  = (gyro_lpm == GYRO_LPM_SUSPEND);
  wire gyro_deep  = (gyro_lpm == GYRO_LPM_DEEP);
  wire gyro_run   = !gyro_susp && !gyro_deep;
  wire do_write   = byte_done && !first_byte && !is_read;
  wire soft_rst   = do_write && was_gyro && (addr == REG_GYRO_SOFTRST) && (wr_byte == SOFT_RESET_CMD);
  wire tick       = (tick_cnt == TICK_CYCLES);
  wire [6:0] a_off = addr - REG_ACCEL_DATA0;
  wire [6:0] g_off = addr - REG_GYRO_DATA0;
  wire [6:0] t_off = addr - REG_ACCEL_TIME0;
  wire accel_hit  = (addr >= REG_ACCEL_DATA0) && (addr < REG_ACCEL_DATA0 + 7'h06);
  wire gyro_hit   = (addr >= REG_GYRO_DATA0) && (addr < REG_GYRO_DATA0 + 7'h06);
  wire time_hit   = (addr >= REG_ACCEL_TIME0) && (addr < REG_ACCEL_TIME0 + 7'h03);
  wire is_hi      = a_off[0] && accel_hit || g_off[0] && gyro_hit;

  always_comb begin
    read_byte = 8'h00;
    if (was_gyro) begin
      if (gyro_hit) read_byte = gyro_data[{g_off[2:0], 3'b000} +: 8];
      else if (addr == REG_GYRO_LPM) read_byte = gyro_lpm;
      else if (addr == REG_GYRO_LPM + 7'h01) read_byte = gyro_cfg;
    end else begin
      if (addr == REG_ACCEL_ID) read_byte = ACCEL_ID_VALUE;
      else if (accel_hit) read_byte = accel_data[{a_off[2:0], 3'b000} +: 8];
      else if (time_hit) read_byte = stime[{t_off[1:0], 3'b000} +: 8];
      else if (addr == REG_ACCEL_TEMP0) read_byte = temp_data[10:3];
      else if (addr == REG_ACCEL_TEMP0 + 7'h01) read_byte = {temp_data[2:0], 5'h00};
      else if (addr == REG_ACCEL_PWR) read_byte = accel_pwr;
    end
    // Outside a burst, high byte comes from the shadow taken at the low byte read
    if (is_hi && !burst_active) read_byte = shadow_hi;
    miso_bit_src = read_byte;
  end

  // Interface selection; reset is the power-on reset
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      accel_spi <= 1'b0;
      gyro_spi  <= 1'b0;
    end else begin
      gyro_spi <= link.interface_select_pin;
      if (acs_rise) accel_spi <= 1'b1;
    end
  end

  // Power registers and gyro config
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      accel_pwr <= ACCEL_PWR_OFF;
      gyro_lpm  <= GYRO_LPM_NORMAL;
      gyro_cfg  <= 8'h00;
    end else if (soft_rst) begin
      gyro_lpm <= GYRO_LPM_NORMAL;
      gyro_cfg <= 8'h00;
    end else begin
      if (do_write && !was_gyro && (addr == REG_ACCEL_PWR)) accel_pwr <= wr_byte;
      if (do_write && was_gyro && (addr == REG_GYRO_LPM)) gyro_lpm <= wr_byte;
      if (do_write && was_gyro && (addr == REG_GYRO_LPM + 7'h01)) gyro_cfg <= wr_byte;
      if (gyro_deep) gyro_cfg <= 8'h00;
    end
  end

  // Sample capture, held while a burst holds the data lock
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      accel_data <= 48'h0;
      gyro_data  <= 48'h0;
      temp_data  <= 11'h0;
    end else if (i_sample_strobe && !burst_active) begin
      if (accel_on) accel_data <= i_accel_sample;
      if (accel_on) temp_data <= i_temp_sample;
      if (gyro_run) gyro_data <= i_gyro_sample;
    end
  end

  // Sensor time
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt <= 9'h0;
      stime    <= 24'h0;
    end else begin
      tick_cnt <= tick ? 9'h0 : tick_cnt + 9'h1;
      if (tick) stime <= stime + 24'h1;
    end
  end

  // SPI slave: mode 0, command byte then data bytes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_in     <= 16'h0;
      shift_out    <= 8'h00;
      bit_cnt      <= 4'h0;
      is_read      <= 1'b0;
      first_byte   <= 1'b1;
      addr         <= 7'h00;
      burst_active <= 1'b0;
      shadow_hi    <= 8'h00;
      was_gyro     <= 1'b0;
    end else if (!any_sel || frame_end) begin
      bit_cnt      <= 4'h0;
      first_byte   <= 1'b1;
      burst_active <= 1'b0;
    end else begin
      if (sck_rise) begin
        shift_in <= {shift_in[14:0], mosi_q};
        bit_cnt  <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
      end
      if (sck_fall && !first_byte) shift_out <= {shift_out[6:0], 1'b0};
      if (byte_done && first_byte) begin
        first_byte <= 1'b0;
        is_read    <= shift_in[6];
        addr       <= {shift_in[5:0], mosi_q};
        was_gyro   <= sel_gyro;
      end else if (byte_done) begin
        addr <= addr + 7'h01;
        if (is_read) burst_active <= 1'b1;
      end
      // Load next byte; low byte read snaps its high partner
      if (sck_fall && bit_cnt == 4'h0 && !first_byte) begin
        shift_out <= miso_bit_src;
        if (!is_hi) begin
          if (accel_hit && !was_gyro) shadow_hi <= accel_data[{a_off[2:0], 3'b000} + 8 +: 8];
          if (gyro_hit && was_gyro) shadow_hi <= gyro_data[{g_off[2:0], 3'b000} + 8 +: 8];
        end
      end
    end
  end

  assign link.miso        = shift_out[7];
  assign link.miso_oe     = any_sel && is_read && !first_byte && (was_gyro ? gyro_spi : accel_spi);
  assign o_accel_spi_mode = accel_spi;
  assign o_gyro_spi_mode  = gyro_spi;
  assign o_accel_active   = accel_on;
  assign o_gyro_mode      = gyro_deep ? 2'h2 : (gyro_susp ? 2'h1 : 2'h0);
  assign o_sensor_time    = stime;
endmodule : imu_sensor
`default_nettype wire

// ===== testbench/imu_power_mode_and_readout_properties.sv
/*
  Link checker: framing and timing on the host to sensor link.
  Assumes the link signals plus the system clock and reset of the pair.
*/
`timescale 1ns/1ps
`default_nettype none
module imu_link_checker
  import imu_pkg::*;
(
  // System
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Link
  input wire logic sck,
  input wire logic accel_cs_n,
  input wire logic gyro_cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic interface_select_pin
);
  // Small margin for reset release latency
  localparam logic [19:0] HOLD_LIM = 20'(GYRO_SETTLE_CYC - 10);
  logic [19:0] since;
  logic [7:0]  rises;
  wire         idle = accel_cs_n && gyro_cs_n;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) since <= 20'h0;
    else if (since != HOLD_LIM) since <= since + 20'h1;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) rises <= 8'h0;
    else if (idle) rises <= 8'h0;
    else if ($rose(sck)) rises <= rises + 8'h1;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_hold; (since != HOLD_LIM) |-> idle; endproperty
  a_hold: assert property (p_hold) else $error("link used in settle wait");
  property p_excl; !idle |-> (accel_cs_n != gyro_cs_n); endproperty
  a_excl: assert property (p_excl) else $error("both selects low");
  property p_sck_idle; idle |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock high outside frame");
  property p_half; $changed(sck) |=> $stable(sck) [*4]; endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_mosi; (sck && $past(sck)) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("data moved while clock high");
  property p_oe; idle [*8] |-> !miso_oe; endproperty
  a_oe: assert property (p_oe) else $error("sensor drives while deselected");
  property p_setup; $fell(idle) |-> (!sck) [*4]; endproperty
  a_setup: assert property (p_setup) else $error("no setup before first clock");
  property p_bytes; $rose(idle) |-> (rises[2:0] == 3'h0) && (rises != 8'h0); endproperty
  a_bytes: assert property (p_bytes) else $error("frame not whole bytes");
  c_frame: cover property ($rose(idle));
  c_gyro: cover property (interface_select_pin && $fell(gyro_cs_n));
  c_data: cover property (miso_oe && miso);
endmodule : imu_link_checker
`default_nettype wire

// ===== testbench/tb_imu_power_mode_and_readout.sv
/*
  Testbench: host and sensor joined on one link; a second sensor on its own
  link is driven by bench tasks, so mode and data checks skip the host wait.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_imu_power_mode_and_readout;
  import imu_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic [47:0] smp = 48'h0;
  logic        strobe = 1'b0;
  logic        spi_a, act_a, spi_b, gspi_b, act_b;
  logic [1:0]  gmode_b;
  logic [23:0] time_b;
  logic [47:0] q;
  logic [31:0] rd;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  imu_link_if link ();
  imu_link_if link_b ();
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;
  imu_host u_imu_host (.i_clk_sys(clk), .i_resetn(rst_n), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(), .link(link));
  imu_sensor u_imu_sensor (.i_clk_sys(clk), .i_resetn(rst_n), .link(link), .i_accel_sample(~smp),
    .i_gyro_sample(smp), .i_temp_sample(smp[10:0]), .i_sample_strobe(strobe), .o_accel_spi_mode(spi_a),
    .o_gyro_spi_mode(), .o_accel_active(act_a), .o_gyro_mode(), .o_sensor_time());
  imu_sensor u_imu_sensor_b (.i_clk_sys(clk), .i_resetn(rst_n), .link(link_b), .i_accel_sample(~smp),
    .i_gyro_sample(smp), .i_temp_sample(smp[10:0]), .i_sample_strobe(strobe), .o_accel_spi_mode(spi_b),
    .o_gyro_spi_mode(gspi_b), .o_accel_active(act_b), .o_gyro_mode(gmode_b), .o_sensor_time(time_b));
  imu_link_checker u_imu_link_checker (.i_clk_sys(clk), .i_resetn(rst_n), .sck(link.sck),
    .accel_cs_n(link.accel_cs_n), .gyro_cs_n(link.gyro_cs_n), .mosi(link.mosi), .miso(link.miso),
    .miso_oe(link.miso_oe), .interface_select_pin(link.interface_select_pin));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [47:0] rev(input logic [47:0] s);
    return {<<8{s}};
  endfunction : rev
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic host_op(input logic [31:0] ctrl, input logic [7:0] a, input logic [7:0] wd);
    ahb(1'b1, HOST_ADDR, {24'h0, a});
    ahb(1'b1, HOST_WDATA, {24'h0, wd});
    ahb(1'b1, HOST_CTRL, ctrl);
    repeat (4) @(posedge clk);
    do ahb(1'b0, HOST_STATUS, 32'h0); while (rd[1:0] !== 2'b01);
    repeat (10) @(posedge clk);
  endtask : host_op
  // Bench as link master; clock only runs inside frames
  task automatic spi(input logic g, input logic r, input logic [6:0] a, input int n, input logic [7:0] wd);
    logic [7:0] tx;
    tx = {r, a};
    @(posedge clk);
    link_b.gyro_cs_n <= !g;
    link_b.accel_cs_n <= g;
    for (int b = 0; b < 8 * (n + 1); b++) begin
      if (b == 8) tx = wd;
      link_b.mosi <= tx[7 - b % 8];
      repeat (4) @(posedge clk);
      link_b.sck <= 1'b1;
      repeat (4) @(posedge clk);
      q = {q[46:0], link_b.miso};
      link_b.sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link_b.gyro_cs_n <= 1'b1;
    link_b.accel_cs_n <= 1'b1;
    link_b.mosi <= !link_b.mosi;
    repeat (WRITE_GAP_CYC) @(posedge clk);
  endtask : spi
  task automatic pulse(input logic [47:0] s);
    @(posedge clk);
    smp <= s;
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
  endtask : pulse
  task automatic t_reset;
    check(48'({spi_b, act_b, gmode_b}), 48'h0);
    check(48'(gspi_b), 48'h1);
    ahb(1'b1, HOST_ADDR, 32'h0);
    ahb(1'b1, HOST_CTRL, 32'h0000_0103);
    ahb(1'b0, HOST_STATUS, 32'h0);
    check(48'(rd[2]), 48'h1);
    repeat (200) @(posedge clk);
    check(48'(spi_a), 48'h0);
  endtask : t_reset
  task automatic t_accel;
    spi(1'b0, 1'b1, REG_ACCEL_ID, 1, 8'h00);
    check(48'(spi_b), 48'h1);
    spi(1'b0, 1'b0, REG_ACCEL_PWR, 1, ACCEL_PWR_ON);
    check(48'(act_b), 48'h1);
    spi(1'b0, 1'b0, REG_ACCEL_PWR, 1, ACCEL_PWR_OFF);
    check(48'(act_b), 48'h0);
  endtask : t_accel
  task automatic t_gyro;
    logic [7:0] code [5] = '{GYRO_LPM_SUSPEND, GYRO_LPM_DEEP, GYRO_LPM_NORMAL, GYRO_LPM_SUSPEND, SOFT_RESET_CMD};
    logic [1:0] mode [5] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
    for (int i = 0; i < 5; i++) begin
      spi(1'b1, 1'b0, (i == 4) ? REG_GYRO_SOFTRST : REG_GYRO_LPM, 1, code[i]);
      check(48'(gmode_b), 48'(mode[i]));
    end
  endtask : t_gyro
  task automatic t_burst;
    pulse(48'hA1A2_B1B2_C1C2);
    fork
      spi(1'b1, 1'b1, REG_GYRO_DATA0, 6, 8'h00);
      begin
        repeat (300) @(posedge clk);
        pulse(48'hD1D2_E1E2_F1F2);
      end
    join
    check(q, rev(48'hA1A2_B1B2_C1C2));
    spi(1'b1, 1'b1, REG_GYRO_DATA0, 6, 8'h00);
    check(q, rev(48'hA1A2_B1B2_C1C2));
  endtask : t_burst
  task automatic t_shadow;
    pulse(48'h1234_5678_9ABC);
    spi(1'b1, 1'b1, REG_GYRO_DATA0, 1, 8'h00);
    check(48'(q[7:0]), 48'hBC);
    pulse(48'h7788_99AA_BBCC);
    spi(1'b1, 1'b1, REG_GYRO_DATA0 + 7'h01, 1, 8'h00);
    check(48'(q[7:0]), 48'h9A);
  endtask : t_shadow
  task automatic t_suspend;
    spi(1'b1, 1'b0, REG_GYRO_LPM, 1, GYRO_LPM_SUSPEND);
    pulse(48'h0F0E_0D0C_0B0A);
    spi(1'b1, 1'b1, REG_GYRO_DATA0, 6, 8'h00);
    check(q, rev(48'h7788_99AA_BBCC));
    spi(1'b1, 1'b0, REG_GYRO_LPM, 1, GYRO_LPM_NORMAL);
  endtask : t_suspend
  task automatic t_time;
    logic [23:0] t0;
    int          n;
    n = 0;
    @(posedge clk);
    t0 = time_b;
    while (time_b === t0) @(posedge clk);
    t0 = time_b;
    while (time_b === t0) begin
      @(posedge clk);
      n++;
    end
    check(48'(n), 48'(TICK_CYCLES) + 48'h1);
    check(48'(time_b), 48'(t0 + 24'h1));
  endtask : t_time
  task automatic t_host;
    wait (cyc >= GYRO_SETTLE_CYC - 50);
    ahb(1'b0, HOST_STATUS, 32'h0);
    check(48'(rd[2]), 48'h1);
    wait (cyc >= GYRO_SETTLE_CYC + 50);
    ahb(1'b0, HOST_STATUS, 32'h0);
    check(48'(rd[2]), 48'h0);
    host_op(32'h0000_0103, {1'b0, REG_ACCEL_ID}, 8'h00);
    check(48'(spi_a), 48'h1);
    pulse(48'h1122_3344_5566);
    host_op(32'h0000_0207, {1'b0, REG_GYRO_DATA0}, 8'h00);
    ahb(1'b0, HOST_RDATA, 32'h0);
    check(48'(rd[15:0]), 48'h5566);
    ahb(1'b0, 8'h20, 32'h0);
    check(48'(rd), 48'h0);
    host_op(32'h0000_0101, {1'b0, REG_ACCEL_PWR}, ACCEL_PWR_ON);
    check(48'(act_a), 48'h1);
  endtask : t_host
  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  initial begin
    link.interface_select_pin = 1'b1;
    link_b.interface_select_pin = 1'b1;
    link_b.sck = 1'b0;
    link_b.mosi = 1'b0;
    link_b.accel_cs_n = 1'b1;
    link_b.gyro_cs_n = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_accel;
    t_gyro;
    t_burst;
    t_shadow;
    t_suspend;
    t_time;
    t_host;
    finish_test;
  end
  // Host settle wait dominates the run
  initial begin
    repeat (400000) @(posedge clk);
    bad_count++;
    finish_test;
  end
endmodule : tb_imu_power_mode_and_readout
`default_nettype wire
